/* hdl/imr_redirect.sv */
`timescale 1ns/1ns
// Summary of operation
// - Interrupts reach cores only as bus messages, never a sideband wire.
// - Processor interrupts use same window with request codes 01001 and 11100.
// - Hint set allows delivery to another processor for lowest priority.
// - Redirection target on any of the buses; applies to I/O and interprocessor interrupts.
// - Redirect in physical mode and logical flat or clustered mode.
// - Address bits 19:12 form the 8-bit destination identifier.
// - Address bits 11:4 are reserved and ignored for delivery.
// - Address bit 3 is the hint: 0 fixed, 1 redirectable.
// - Address bit 2 selects physical (0) or logical (1) destination.
// - I/O-side encoding bit copied into bus address bit five.
// - Data: vector 7:0, delivery 10:8, status 14, trigger 15.
module imr_redirect
    import imr_pkg::*;
#(
    parameter int ADDR_W = 32,
    parameter int DATA_W = 64
) (
    input  wire logic              ref_clk,                  // Bus clock
    input  wire logic              rst,                      // Async reset, high
    input  wire logic              req_valid,                // Incoming request
    input  wire logic              req_from_io,              // Request came from I/O side
    input  wire logic              req_is_write,             // Memory write request
    input  wire logic [4:0]        request_phase_code_first, // First request code
    input  wire logic [4:0]        request_phase_code_second,// Second request code
    input  wire logic [ADDR_W-1:0] req_addr,                 // Request address
    input  wire logic [DATA_W-1:0] req_data,                 // Request data
    input  wire logic              io_encoding_bit,          // I/O transaction encoding
    input  wire logic              redirect_enable,          // Allow redirection
    input  wire logic [7:0]        redirect_dest,            // Chosen alternate target
    input  wire logic [1:0]        redirect_bus,             // Bus of alternate target
    input  wire logic [1:0]        addressed_bus,            // Bus of addressed target
    input  wire logic [1:0]        logical_model,            // Logical model selector
    input  wire logic              msg_ready,                // Bus can take message
    output logic                   req_ready,                // Request accepted
    output logic                   msg_valid,                // Interrupt message out
    output logic [1:0]             msg_bus,                  // Target processor bus
    output logic [ADDR_W-1:0]      msg_addr,                 // Bus message address
    output logic [7:0]             msg_vector,               // Vector
    output logic [2:0]             msg_delivery,             // Delivery mode
    output logic                   msg_status,               // Delivery status
    output logic                   msg_trigger,              // Trigger mode
    output logic                   msg_redirected,           // Target was changed
    output imr_model_t             msg_model,                // Addressing model used
    output logic                   msg_is_ipi                // Interprocessor origin
);

    // Decode of the incoming request
    logic       in_window;
    logic       io_msg;
    logic       cpu_msg;
    logic       take;
    logic [7:0] destination_identifier;
    logic       redirection_hint;
    logic       destination_mode_bit;
    logic       do_redirect;
    imr_model_t next_model;
    logic [ADDR_W-1:0] next_addr;
    logic [1:0] next_bus;
    logic       next_redirected;

    // Only the top twelve bits pick out the interrupt window
    // window match
    assign in_window = (req_addr[IMR_WIN_HI:IMR_WIN_LO] == IMR_ADDR_WINDOW);

    // I/O reads in the window are not interrupts and are ignored
    // I/O write recognition
    assign io_msg = req_from_io && req_is_write && in_window;

    // Both codes must match; one alone is ordinary traffic
    // processor code match
    assign cpu_msg = !req_from_io && in_window
                     && (request_phase_code_first == IMR_REQ_FIRST)
                     && (request_phase_code_second == IMR_REQ_SECOND);

    // A message the bus has not taken stalls the source; one slot keeps ordering simple
    // A busy bus therefore backs up into the requester
    assign req_ready = !msg_valid || msg_ready;
    assign take      = req_valid && req_ready && (io_msg || cpu_msg);

    assign destination_identifier = req_addr[IMR_DEST_HI:IMR_DEST_LO];
    assign redirection_hint       = req_addr[IMR_HINT_BIT];
    assign destination_mode_bit   = req_addr[IMR_MODE_BIT];

    assign do_redirect = redirection_hint && redirect_enable;

    assign next_bus        = do_redirect ? redirect_bus : addressed_bus;
    assign next_redirected = do_redirect;

    always_comb begin
        if (!destination_mode_bit) begin
            next_model = IMR_PHYSICAL;
        end else if (logical_model == 2'b10) begin
            next_model = IMR_CLUSTER;
        end else begin
            // Any selector value but clustered falls back to flat
            next_model = IMR_FLAT;
        end
    end

    // Outgoing address; field 11:4 passed unused, except bit 5 on I/O requests
    always_comb begin
        // Hint and mode bits travel unchanged for the bus side
        next_addr = req_addr;
        next_addr[IMR_DEST_HI:IMR_DEST_LO] = do_redirect ? redirect_dest
                                                         : destination_identifier;
        if (req_from_io) begin
            next_addr[IMR_BIT_FIVE] = io_encoding_bit;
        end
        next_addr[1:0] = 2'b00;
    end

    // message issued on bus; a fresh take outranks the drain
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            msg_valid <= 1'b0;
        end else if (take) begin
            msg_valid <= 1'b1;
        end else if (msg_ready) begin
            msg_valid <= 1'b0;
        end
    end

    // Address, held until the bus accepts it
    // Loads only on a take, so a stalled message stands unchanged
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            msg_addr <= '0;
        end else if (take) begin
            msg_addr <= next_addr;
        end
    end

    // Alternate bus comes from the target choice outside this block
    // target bus, held with the address
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            msg_bus <= IMR_BUS_RST;
        end else if (take) begin
            msg_bus <= next_bus;
        end
    end

    // Reset value says no redirect has happened
    // redirect flag for the bus side
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            msg_redirected <= 1'b0;
        end else if (take) begin
            msg_redirected <= next_redirected;
        end
    end

    // Stored so the bus side need not re-decode the mode bit
    // addressing model used
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            msg_model <= IMR_PHYSICAL;
        end else if (take) begin
            msg_model <= next_model;
        end
    end

    // Lets the bus side tell processor traffic from I/O traffic
    // processor origin marker
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            msg_is_ipi <= 1'b0;
        end else if (take) begin
            msg_is_ipi <= cpu_msg;
        end
    end

    // Data bits 63:16 and 13:11 are don't-care and never stored
    // vector field
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            msg_vector <= IMR_VEC_RST;
        end else if (take) begin
            msg_vector <= req_data[IMR_VEC_HI:IMR_VEC_LO];
        end
    end

    // Delivery mode is passed on as received, never re-coded
    // delivery mode field
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            msg_delivery <= IMR_DLV_RST;
        end else if (take) begin
            msg_delivery <= req_data[IMR_DLV_HI:IMR_DLV_LO];
        end
    end

    // Status and trigger are single bits, copied as they stand
    // delivery status bit
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            msg_status <= 1'b0;
        end else if (take) begin
            msg_status <= req_data[IMR_STAT_BIT];
        end
    end

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            msg_trigger <= 1'b0;
        end else if (take) begin
            msg_trigger <= req_data[IMR_TRIG_BIT];
        end
    end

endmodule : imr_redirect

/* hdl/imr_pkg.sv */
package imr_pkg;

    // Interrupt address window, upper address bits
    localparam logic [11:0] IMR_ADDR_WINDOW   = 12'hFEE;
    localparam int          IMR_WIN_HI        = 31;
    localparam int          IMR_WIN_LO        = 20;
    // Address field positions
    localparam int          IMR_DEST_HI       = 19;
    localparam int          IMR_DEST_LO       = 12;
    localparam int          IMR_EXT_HI        = 11;
    localparam int          IMR_EXT_LO        = 4;
    localparam int          IMR_HINT_BIT      = 3;
    localparam int          IMR_MODE_BIT      = 2;
    localparam int          IMR_BIT_FIVE      = 5;
    // Data field positions
    localparam int          IMR_VEC_HI        = 7;
    localparam int          IMR_VEC_LO        = 0;
    localparam int          IMR_DLV_HI        = 10;
    localparam int          IMR_DLV_LO        = 8;
    localparam int          IMR_STAT_BIT      = 14;
    localparam int          IMR_TRIG_BIT      = 15;
    // Request-phase codes of a processor interrupt
    localparam logic [4:0]  IMR_REQ_FIRST     = 5'h09;
    localparam logic [4:0]  IMR_REQ_SECOND    = 5'h1C;
    // Reset values
    localparam logic [7:0]  IMR_DEST_RST      = 8'h00;
    localparam logic [1:0]  IMR_BUS_RST       = 2'h0;
    localparam logic [7:0]  IMR_VEC_RST       = 8'h00;
    localparam logic [2:0]  IMR_DLV_RST       = 3'h0;

    // Addressing model, physical or logical
    typedef enum logic [1:0] {
        IMR_PHYSICAL = 2'b00,
        IMR_FLAT     = 2'b01,
        IMR_CLUSTER  = 2'b10
    } imr_model_t;

endpackage : imr_pkg

/* sim/imr_monitor.sv */
`timescale 1ns/1ns
module imr_monitor (
    input wire logic        ref_clk,         // Bus clock
    input wire logic        rst,             // Async reset
    input wire logic        req_valid,       // Request present
    input wire logic        req_from_io,     // I/O origin
    input wire logic        req_is_write,    // Memory write
    input wire logic [31:0] req_addr,        // Request address
    input wire logic [63:0] req_data,        // Request data
    input wire logic        io_encoding_bit, // I/O encoding
    input wire logic        redirect_enable, // Redirection allowed
    input wire logic [7:0]  redirect_dest,   // Alternate target
    input wire logic        req_ready,       // Request accepted
    input wire logic        msg_ready,       // Bus takes message
    input wire logic        msg_valid,       // Message out
    input wire logic [31:0] msg_addr,        // Message address
    input wire logic [7:0]  msg_vector,      // Vector
    input wire logic        msg_trigger      // Trigger mode
);
    // Only I/O writes here; processor codes are judged by the bench
    wire take = req_valid && req_ready && req_from_io && req_is_write
                && req_addr[31:20] == 12'hFEE;
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (rst);
    chk_answer_next: assert property (take |=> msg_valid)
        else $error("no message after window write");
    chk_hold_stall: assert property (msg_valid && !msg_ready |=> msg_valid && $stable(msg_addr))
        else $error("message lost while bus stalled");
    chk_ready_rel: assert property (req_ready == (!msg_valid || msg_ready))
        else $error("request ready wrong");
    chk_dest_kept: assert property (take && !(req_addr[3] && redirect_enable)
        |=> msg_addr[19:12] == $past(req_addr[19:12])) else $error("destination changed");
    chk_redirect_dest: assert property (take && req_addr[3] && redirect_enable
        |=> msg_addr[19:12] == $past(redirect_dest)) else $error("redirect target not used");
    chk_reserved_pass: assert property (take |=> msg_addr[11:6] == $past(req_addr[11:6]))
        else $error("reserved field altered");
    chk_bit_five: assert property (take |=> msg_addr[5] == $past(io_encoding_bit))
        else $error("bit five not copied");
    chk_data_fields: assert property (take |=> msg_vector == $past(req_data[7:0])
        && msg_trigger == $past(req_data[15])) else $error("data fields wrong");
    chk_low_bits: assert property (msg_valid |-> msg_addr[1:0] == 2'b00)
        else $error("low address bits not zero");
    chk_window_miss: assert property (req_valid && req_addr[31:20] != 12'hFEE
        && !msg_valid |=> !msg_valid) else $error("message outside window");
endmodule : imr_monitor
bind imr_redirect imr_monitor u_mon (.ref_clk(ref_clk), .rst(rst), .req_valid(req_valid),
    .req_from_io(req_from_io), .req_is_write(req_is_write), .req_addr(req_addr),
    .req_data(req_data), .io_encoding_bit(io_encoding_bit), .req_ready(req_ready),
    .redirect_enable(redirect_enable), .redirect_dest(redirect_dest),
    .msg_ready(msg_ready), .msg_valid(msg_valid), .msg_addr(msg_addr),
    .msg_vector(msg_vector), .msg_trigger(msg_trigger));

/* sim/imr_bus_sink.sv */
`timescale 1ns/1ns
module imr_bus_sink (
    input  wire logic stall,    // Bench asks for a slow bus
    output logic      msg_ready // Bus takes message
);
    // messages leave only over the bus; stall models a busy bus
    assign msg_ready = !stall;
endmodule : imr_bus_sink

/* sim/imr_redirect_tb_top.sv */
`timescale 1ns/1ns
`define CHK(n, e, s) begin num_checks++; if ((s) !== (e)) begin failures++; \
    $display("[ERR] %s exp %0h got %0h", n, e, s); end end
module imr_redirect_tb_top;
    import imr_pkg::*;
    logic ref_clk = 0, rst = 1, req_valid = 0, req_from_io = 0, req_is_write = 0, io_enc = 0;
    logic ren = 0, stall = 0, msg_ready, req_ready, msg_valid, m_stat, m_trig, m_red, m_ipi;
    logic [4:0] c1 = 0, c2 = 0;
    logic [31:0] req_addr = 0, m_addr;
    logic [63:0] req_data = 0;
    logic [7:0] rdest = 0, m_vec;
    logic [2:0] m_dlv;
    logic [1:0] rbus = 0, abus = 0, lmod = 0, m_bus;
    imr_model_t m_model;
    int failures = 0, num_checks = 0;
    imr_redirect DUT (.ref_clk(ref_clk), .rst(rst), .req_valid(req_valid),
        .req_from_io(req_from_io), .req_is_write(req_is_write), .request_phase_code_first(c1),
        .request_phase_code_second(c2), .req_addr(req_addr), .req_data(req_data),
        .io_encoding_bit(io_enc), .redirect_enable(ren), .redirect_dest(rdest),
        .redirect_bus(rbus), .addressed_bus(abus), .logical_model(lmod), .msg_ready(msg_ready),
        .req_ready(req_ready), .msg_valid(msg_valid), .msg_bus(m_bus), .msg_addr(m_addr),
        .msg_vector(m_vec), .msg_delivery(m_dlv), .msg_status(m_stat), .msg_trigger(m_trig),
        .msg_redirected(m_red), .msg_model(m_model), .msg_is_ipi(m_ipi));
    imr_bus_sink u_sink (.stall(stall), .msg_ready(msg_ready));
    // Clock at 40 ns
    initial begin
        forever #20 ref_clk = ~ref_clk;
    end
    // Hold request until the edge that sees ready, then drop it
    task automatic send(input logic io, input logic wr, input logic [4:0] a1, a2,
                        input logic [31:0] a, input logic [63:0] d);
        int n;
        n = 0;
        req_from_io = io;
        req_is_write = wr;
        c1 = a1;
        c2 = a2;
        req_addr = a;
        req_data = d;
        req_valid = 1;
        #1;
        while (req_ready !== 1'b1 && n < 20) begin
            @(posedge ref_clk);
            #1;
            n++;
        end
        if (n == 20) begin
            failures++;
            end_of_test();
        end
        @(posedge ref_clk);
        #2 req_valid = 0;
    endtask : send
    task automatic t_io;
        abus = 2'h2;
        ren = 1;
        rdest = 8'h44;
        rbus = 2'h3;
        send(1, 1, 5'h00, 5'h00, 32'hFEE5_AC33, 64'hDEAD_BEEF_1234_CDA7);
        `CHK("addr", 32'hFEE5_AC10, m_addr)
        `CHK("fields", 13'h1DA7, {m_trig, m_stat, m_dlv, m_vec})
        `CHK("route", 5'h11, {m_bus, m_red, m_ipi, msg_valid})
        `CHK("model", IMR_PHYSICAL, m_model)
        @(posedge ref_clk);
        #2 io_enc = 1;
        send(1, 1, 5'h00, 5'h00, 32'hFEE2_3408, 64'h0);
        `CHK("io redirect", 32'hFEE4_4428, m_addr)
        `CHK("io route", 5'h1D, {m_bus, m_red, m_ipi, msg_valid})
        @(posedge ref_clk);
        #2 ren = 0;
        send(1, 1, 5'h00, 5'h00, 32'hFEE2_3408, 64'h0);
        `CHK("hint only", 32'hFEE2_3428, m_addr)
        `CHK("kept route", 5'h11, {m_bus, m_red, m_ipi, msg_valid})
    endtask : t_io
    task automatic t_ipi(input logic [1:0] lm, input imr_model_t em);
        lmod = lm;
        rdest = 8'h77;
        rbus = 2'h1;
        ren = 1;
        @(posedge ref_clk);
        #2 send(0, 0, IMR_REQ_FIRST, IMR_REQ_SECOND, 32'hFEE1_230F, 64'h31);
        `CHK("ipi addr", 32'hFEE7_730C, m_addr)
        `CHK("ipi route", 5'h0F, {m_bus, m_red, m_ipi, msg_valid})
        `CHK("ipi model", em, m_model)
        `CHK("ipi vec", 8'h31, m_vec)
    endtask : t_ipi
    task automatic t_bad;
        @(posedge ref_clk);
        #2 send(0, 0, IMR_REQ_FIRST, 5'h1D, 32'hFEE1_2000, 64'h1);
        `CHK("bad code", 1'b0, msg_valid)
        @(posedge ref_clk);
        #2 send(0, 0, 5'h08, IMR_REQ_SECOND, 32'hFEE1_2000, 64'h1);
        `CHK("bad first", 1'b0, msg_valid)
        @(posedge ref_clk);
        #2 send(1, 1, 5'h00, 5'h00, 32'hFED0_0000, 64'h1);
        `CHK("off window", 1'b0, msg_valid)
        @(posedge ref_clk);
        #2 send(1, 0, 5'h00, 5'h00, 32'hFEE0_0000, 64'h1);
        `CHK("io read", 1'b0, msg_valid)
    endtask : t_bad
    task automatic t_stall;
        stall = 1;
        send(1, 1, 5'h00, 5'h00, 32'hFEE0_0004, 64'h2);
        repeat (3) @(posedge ref_clk);
        #2 `CHK("stall hold", 2'h2, {msg_valid, req_ready})
        stall = 0;
        @(posedge ref_clk);
        #2 `CHK("drained", 1'b0, msg_valid)
    endtask : t_stall
    task automatic t_reset;
        stall = 1;
        send(1, 1, 5'h00, 5'h00, 32'hFEE3_3000, 64'h5);
        `CHK("stalled", 2'h2, {msg_valid, req_ready})
        rst = 1;
        @(posedge ref_clk);
        #2 `CHK("reset clear", 34'h1, {msg_valid, m_addr, req_ready})
        rst = 0;
        stall = 0;
        @(posedge ref_clk);
        #2 send(1, 1, 5'h00, 5'h00, 32'hFEE3_3000, 64'h5);
        `CHK("after reset", 32'hFEE3_3020, m_addr)
    endtask : t_reset
    task automatic end_of_test;
        if (failures == 0 && num_checks > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask : end_of_test
    initial begin
        #20000 failures++;
        end_of_test();
    end
    initial begin
        repeat (3) @(posedge ref_clk);
        #2 rst = 0;
        t_io();
        t_ipi(2'b10, IMR_CLUSTER);
        t_ipi(2'b01, IMR_FLAT);
        t_bad();
        t_stall();
        t_reset();
        end_of_test();
    end
endmodule : imr_redirect_tb_top
